// *** core/bbsie_cfg.svh ***
// Constants for the branch and bit/skip instruction executor
// Behaviour
// - A relative jump loads the already-advanced counter plus twice its signed 11-bit offset.
// - A relative jump takes two instruction cycles, the second one idle while refetching.
// - Bit force-one sets bit 0..7 of the addressed file byte in one cycle, flags untouched.
// - Access-select low picks the access bank, high picks the bank chosen by the bank select.
// - With the extended set on, access-select low and file address up to 95, use indexed mode.
// - File invert writes the bitwise inverse in one cycle and updates only negative and zero.
// - Destination low sends the result to the working register, high back to the file byte.
// - Compare-skip subtracts without touching flags and discards the next word when equal.
// - A skip costs one cycle if not taken, two if taken, three over a two-word instruction.
// - Decrement-skip-zero writes file minus one and skips when it is zero, flags untouched.
// - Decrement-skip-nonzero writes file minus one and skips when it is not zero.
`ifndef BBSIE_CFG_SVH
`define BBSIE_CFG_SVH

`define BBSIE_OFS_CTRL 4'h0
`define BBSIE_OFS_BANK 4'h4
`define BBSIE_OFS_WORK 4'h8
`define BBSIE_OFS_STAT 4'hc

`define BBSIE_CTRL_EXT_BIT 0
`define BBSIE_STAT_ZERO_BIT 0
`define BBSIE_STAT_NEG_BIT 1
`define BBSIE_STAT_BUSY_BIT 2

`define BBSIE_CTRL_RST 1'b0
`define BBSIE_BANK_RST 6'h00
`define BBSIE_WORK_RST 8'h00
`define BBSIE_PC_RST 21'h000000
`define BBSIE_PC_STEP 21'h000002

`define BBSIE_Q_READ 2'h1
`define BBSIE_Q_CALC 2'h2
`define BBSIE_Q_LAST 2'h3

`define BBSIE_IDX_MAX 8'h5f
`define BBSIE_ACC_SPLIT 8'h60
`define BBSIE_ACC_LOW_BANK 6'h00
`define BBSIE_ACC_HIGH_BANK 6'h3f

`define BBSIE_F_DEST 9
`define BBSIE_F_ACC 8
`define BBSIE_F_BIT_HI 11
`define BBSIE_F_BIT_LO 9
`define BBSIE_F_FILE_HI 7
`define BBSIE_F_OFS_HI 10

`define BBSIE_OP_JUMP 5'h1a
`define BBSIE_OP_BITSET 4'h8
`define BBSIE_OP_INVERT 6'h07
`define BBSIE_OP_CMPEQ 7'h31
`define BBSIE_OP_DECZ 6'h0b
`define BBSIE_OP_DECNZ 6'h13
`define BBSIE_OP_2W_A 4'hc
`define BBSIE_OP_2W_B 6'h3b

`endif

// *** core/bbsie_pkg.sv ***
// Types shared by the instruction executor
package bbsie_pkg;

  typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_FLUSH2} bbsie_state_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_JUMP, OP_BITSET, OP_INVERT, OP_CMPEQ, OP_DECZ, OP_DECNZ
  } bbsie_op_t;

endpackage : bbsie_pkg

// *** core/bbsie_addr_gen.sv ***
// Data address generation for file-register operands
`timescale 1ns/1ns
`include "bbsie_cfg.svh"

module bbsie_addr_gen (
  input wire logic [7:0] fileAddr,
  input wire logic accSel,
  input wire logic extEnable,
  input wire logic [5:0] bankSel,
  input wire logic [13:0] indexBase,
  output logic [13:0] dataAddr
);

  always_comb begin
    if (!accSel && extEnable && fileAddr <= `BBSIE_IDX_MAX) begin
      dataAddr = indexBase + {6'h00, fileAddr};
    end else if (!accSel) begin
      // Access addresses below 0x60 are RAM, 0x60 and up land on the special registers
      if (fileAddr < `BBSIE_ACC_SPLIT) begin
        dataAddr = {`BBSIE_ACC_LOW_BANK, fileAddr};
      end else begin
        dataAddr = {`BBSIE_ACC_HIGH_BANK, fileAddr};
      end
    end else begin
      dataAddr = {bankSel, fileAddr};
    end
  end

endmodule : bbsie_addr_gen

// *** core/bbsie_core.sv ***
// Decode and execute of jump, bit force, invert, compare-skip and decrement-skip
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "bbsie_cfg.svh"

module bbsie_core
  import bbsie_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic [15:0] instrWord,
  input wire logic [13:0] indexBase,
  output logic [20:0] pc,
  output logic fetchFlush,
  output logic [1:0] qPhase,
  output logic [13:0] memAddr,
  output logic memRead,
  input wire logic [7:0] memReadData,
  output logic memWrite,
  output logic [7:0] memWriteData
);

  bbsie_state_t state;
  bbsie_op_t opReg;
  logic [15:0] instrReg;
  logic extEnable;
  logic [5:0] bankSel;
  logic [7:0] wReg;
  logic zeroFlag;
  logic negFlag;
  logic skipPend;
  logic flushIsSkip;
  logic extraFlush;
  logic [13:0] nextAddr;
  logic [7:0] result;
  logic skipNow;
  logic writesFile;
  logic writesW;
  logic [20:0] jumpTarget;
  logic [7:0] bitMask;

  function automatic bbsie_op_t decodeOp(input logic [15:0] w);
    bbsie_op_t op;
    op = OP_NONE;
    if (w[15:11] == `BBSIE_OP_JUMP) begin
      op = OP_JUMP;
    end else if (w[15:12] == `BBSIE_OP_BITSET) begin
      op = OP_BITSET;
    end else if (w[15:10] == `BBSIE_OP_INVERT) begin
      op = OP_INVERT;
    end else if (w[15:9] == `BBSIE_OP_CMPEQ) begin
      op = OP_CMPEQ;
    end else if (w[15:10] == `BBSIE_OP_DECZ) begin
      op = OP_DECZ;
    end else if (w[15:10] == `BBSIE_OP_DECNZ) begin
      op = OP_DECNZ;
    end
    return op;
  endfunction : decodeOp

  function automatic logic isFileOp(input bbsie_op_t op);
    return op != OP_NONE && op != OP_JUMP;
  endfunction : isFileOp

  // Words that carry a second program word behind them
  function automatic logic isTwoWord(input logic [15:0] w);
    return w[15:12] == `BBSIE_OP_2W_A || w[15:10] == `BBSIE_OP_2W_B;
  endfunction : isTwoWord

  bbsie_addr_gen u_addr_gen (
    .fileAddr(instrWord[`BBSIE_F_FILE_HI:0]),
    .accSel(instrWord[`BBSIE_F_ACC]),
    .extEnable(extEnable),
    .bankSel(bankSel),
    .indexBase(indexBase),
    .dataAddr(nextAddr)
  );

  // Four clock phases make one instruction cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      qPhase <= 2'h0;
    end else begin
      qPhase <= qPhase + 2'h1;
    end
  end

  // Decode phase: latch the word, or drop it while flushing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      instrReg <= 16'h0000;
      opReg <= OP_NONE;
      extraFlush <= 1'b0;
    end else if (qPhase == 2'h0) begin
      if (state == ST_EXEC) begin
        instrReg <= instrWord;
        opReg <= decodeOp(instrWord);
        extraFlush <= 1'b0;
      end else begin
        opReg <= OP_NONE;
        // A skipped two-word instruction costs one more idle cycle
        extraFlush <= state == ST_FLUSH && flushIsSkip && isTwoWord(instrWord);
      end
    end
  end

  // Operand read is issued for the read phase only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      memAddr <= 14'h0000;
      memRead <= 1'b0;
    end else begin
      memRead <= qPhase == 2'h0 && state == ST_EXEC && isFileOp(decodeOp(instrWord));
      if (qPhase == 2'h0 && state == ST_EXEC) begin
        memAddr <= nextAddr;
      end
    end
  end

  assign bitMask = 8'h01 << instrReg[`BBSIE_F_BIT_HI:`BBSIE_F_BIT_LO];
  assign jumpTarget = pc + {{9{instrReg[`BBSIE_F_OFS_HI]}}, instrReg[`BBSIE_F_OFS_HI:0], 1'b0};

  always_comb begin
    result = memReadData;
    skipNow = 1'b0;
    unique case (opReg)
      OP_BITSET: result = memReadData | bitMask;
      OP_INVERT: result = ~memReadData;
      OP_CMPEQ: begin
        // Unsigned difference only decides the skip; nothing is stored
        result = memReadData - wReg;
        skipNow = result == 8'h00;
      end
      OP_DECZ: begin
        result = memReadData - 8'h01;
        skipNow = result == 8'h00;
      end
      OP_DECNZ: begin
        result = memReadData - 8'h01;
        skipNow = result != 8'h00;
      end
      OP_NONE, OP_JUMP: result = memReadData;
      default: result = memReadData;
    endcase
  end

  always_comb begin
    writesFile = 1'b0;
    writesW = 1'b0;
    if (opReg == OP_BITSET) begin
      writesFile = 1'b1;
    end else if (opReg == OP_INVERT || opReg == OP_DECZ || opReg == OP_DECNZ) begin
      writesFile = instrReg[`BBSIE_F_DEST];
      writesW = !instrReg[`BBSIE_F_DEST];
    end
  end

  // Result write lands in the last phase
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      memWrite <= 1'b0;
      memWriteData <= 8'h00;
    end else begin
      memWrite <= qPhase == `BBSIE_Q_CALC && writesFile;
      if (qPhase == `BBSIE_Q_CALC) begin
        memWriteData <= result;
      end
    end
  end

  // Working register: an instruction result wins over a software write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wReg <= `BBSIE_WORK_RST;
    end else if (qPhase == `BBSIE_Q_CALC && writesW) begin
      wReg <= result;
    end else if (regWrite && regAddr == `BBSIE_OFS_WORK) begin
      wReg <= regWrData;
    end
  end

  // Only the invert touches flags; the skip family leaves them alone
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      zeroFlag <= 1'b0;
      negFlag <= 1'b0;
    end else if (qPhase == `BBSIE_Q_CALC && opReg == OP_INVERT) begin
      zeroFlag <= result == 8'h00;
      negFlag <= result[7];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      skipPend <= 1'b0;
    end else if (qPhase == `BBSIE_Q_CALC) begin
      skipPend <= skipNow;
    end
  end

  // Cycle sequencing; flush cycles execute nothing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ST_EXEC;
      flushIsSkip <= 1'b0;
    end else if (qPhase == `BBSIE_Q_LAST) begin
      unique case (state)
        ST_EXEC: begin
          if (opReg == OP_JUMP || skipPend) begin
            state <= ST_FLUSH;
          end
          flushIsSkip <= skipPend;
        end
        ST_FLUSH: state <= extraFlush ? ST_FLUSH2 : ST_EXEC;
        ST_FLUSH2: state <= ST_EXEC;
      endcase
    end
  end

  // Counter already points past the executing word when the jump adds its offset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc <= `BBSIE_PC_RST;
    end else if (qPhase == `BBSIE_Q_LAST) begin
      if (state == ST_EXEC && opReg == OP_JUMP) begin
        pc <= jumpTarget;
      end else begin
        pc <= pc + `BBSIE_PC_STEP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fetchFlush <= 1'b0;
    end else begin
      fetchFlush <= qPhase == `BBSIE_Q_LAST && state == ST_EXEC &&
        (opReg == OP_JUMP || skipPend);
    end
  end

  // Software control registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      extEnable <= `BBSIE_CTRL_RST;
      bankSel <= `BBSIE_BANK_RST;
    end else if (regWrite) begin
      if (regAddr == `BBSIE_OFS_CTRL) begin
        extEnable <= regWrData[`BBSIE_CTRL_EXT_BIT];
      end
      if (regAddr == `BBSIE_OFS_BANK) begin
        bankSel <= regWrData[5:0];
      end
    end
  end

  // Read data stand for one cycle only; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (!regRead) begin
      regRdData <= 8'h00;
    end else begin
      unique case (regAddr)
        `BBSIE_OFS_CTRL: regRdData <= {7'h00, extEnable};
        `BBSIE_OFS_BANK: regRdData <= {2'h0, bankSel};
        `BBSIE_OFS_WORK: regRdData <= wReg;
        `BBSIE_OFS_STAT: regRdData <= {5'h00, state != ST_EXEC, negFlag, zeroFlag};
        default: regRdData <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!resetn);

  AST_JUMP_TARGET: assert property (
    qPhase == `BBSIE_Q_LAST && state == ST_EXEC && opReg == OP_JUMP
    |=> pc == $past(jumpTarget) && $past(jumpTarget) == $past(pc) +
      {{9{$past(instrReg[10])}}, $past(instrReg[10:0]), 1'b0})
    else $error("jump target wrong");

  AST_JUMP_TWO_CYCLES: assert property (
    qPhase == `BBSIE_Q_LAST && state == ST_EXEC && opReg == OP_JUMP
    |=> fetchFlush ##0 (state == ST_FLUSH && !memWrite)[*4] ##1 state == ST_EXEC)
    else $error("jump did not idle exactly one cycle");

  AST_BITSET: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_BITSET
    |=> memWrite && memWriteData == ($past(memReadData) | $past(bitMask)) &&
      $stable(zeroFlag) && $stable(negFlag))
    else $error("bit force-one result wrong");

  AST_BANKED: assert property (
    qPhase == 2'h0 && state == ST_EXEC && isFileOp(decodeOp(instrWord)) &&
      instrWord[`BBSIE_F_ACC]
    |=> memAddr == {$past(bankSel), $past(instrWord[7:0])} ##0 memRead)
    else $error("banked address wrong");

  AST_INDEXED: assert property (
    qPhase == 2'h0 && state == ST_EXEC && isFileOp(decodeOp(instrWord)) &&
      !instrWord[`BBSIE_F_ACC] && extEnable && instrWord[7:0] <= `BBSIE_IDX_MAX
    |=> memAddr == $past(indexBase) + {6'h00, $past(instrWord[7:0])})
    else $error("indexed address wrong");

  AST_INVERT_FLAGS: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_INVERT
    |=> zeroFlag == ($past(memReadData) == 8'hff) && negFlag == !$past(memReadData[7]))
    else $error("invert flags wrong");

  AST_DEST_WORK: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_DECZ && !instrReg[`BBSIE_F_DEST]
    |=> !memWrite && wReg == $past(memReadData) - 8'h01)
    else $error("working register destination wrong");

  AST_CMP_SKIP: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_CMPEQ && memReadData == wReg
    |=> !memWrite && $stable(zeroFlag) ##1 state == ST_FLUSH && fetchFlush)
    else $error("equal compare did not skip");

  AST_SKIP_THREE: assert property (
    qPhase == 2'h0 && state == ST_FLUSH && flushIsSkip && isTwoWord(instrWord)
    |=> ##3 state == ST_FLUSH2 ##4 state == ST_EXEC)
    else $error("two-word skip not three cycles");

  AST_NO_SKIP_ONE: assert property (
    qPhase == `BBSIE_Q_CALC && state == ST_EXEC && isFileOp(opReg) && !skipNow
    |=> ##1 state == ST_EXEC && !fetchFlush)
    else $error("untaken skip cost extra cycle");

  AST_DECZ: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_DECZ && memReadData == 8'h01
    |=> $stable(negFlag) && $stable(zeroFlag) ##1 state == ST_FLUSH)
    else $error("decrement to zero did not skip");

  AST_DECNZ: assert property (
    qPhase == `BBSIE_Q_CALC && opReg == OP_DECNZ
    |=> ##1 (state == ST_FLUSH) == ($past(memReadData, 2) != 8'h01))
    else $error("decrement nonzero skip wrong");

endmodule : bbsie_core

// *** testbench/bbsie_mem_model.sv ***
// Banked data memory model that answers one clock after each read strobe
`timescale 1ns/1ns
module bbsie_mem_model (
  input wire logic ref_clk,
  input wire logic [13:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWriteData,
  output logic [7:0] memReadData
);
  logic [7:0] store [16384];
  task automatic poke(input logic [13:0] a, input logic [7:0] d);
    store[a] = d;
  endtask : poke
  initial memReadData = 8'h00;
  // Outside a read the bus flips every clock, so a late sample cannot pass by luck
  always @(posedge ref_clk) begin
    if (memRead) memReadData <= store[memAddr];
    else memReadData <= ~memReadData;
    if (memWrite) store[memAddr] <= memWriteData;
  end
endmodule : bbsie_mem_model

// *** testbench/branch_bit_skip_instr_exec_test.sv ***
// Self-checking bench for the instruction executor
`timescale 1ns/1ns
`define CK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module branch_bit_skip_instr_exec_test;
  logic ref_clk = 0;
  logic resetn = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWrData = 0;
  logic regWrite = 0;
  logic regRead = 0;
  logic [15:0] instrWord = 0;
  logic [13:0] indexBase = 0;
  logic [7:0] regRdData, memReadData, memWriteData;
  logic [20:0] pc;
  logic [1:0] qPhase;
  logic [13:0] memAddr;
  logic fetchFlush, memRead, memWrite;
  int err_total = 0;
  int checks = 0;
  int flushN = 0;
  int forceM = -1;
  logic [20:0] pcE = 0;
  logic [5:0] bank = 0;
  logic [7:0] wr = 0;
  logic ffE = 0, firstFl = 0, ext = 0, zf = 0, nf = 0;

  bbsie_core uut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .instrWord(instrWord), .indexBase(indexBase), .pc(pc), .fetchFlush(fetchFlush),
    .qPhase(qPhase), .memAddr(memAddr), .memRead(memRead), .memReadData(memReadData),
    .memWrite(memWrite), .memWriteData(memWriteData));
  bbsie_mem_model mem (.ref_clk(ref_clk), .memAddr(memAddr), .memRead(memRead),
    .memWrite(memWrite), .memWriteData(memWriteData), .memReadData(memReadData));

  task close_out;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // One instruction cycle; rk 1 writes register ra, rk 2 reads it expecting rd
  task automatic slot(input logic [15:0] w, input int rk, input logic [3:0] ra,
                      input logic [7:0] rd);
    logic [13:0] ix, a;
    logic [7:0] f, m, r;
    logic rdE, wrE, dW, sk, fl;
    ix = 14'($urandom);
    f = w[7:0];
    m = (forceM >= 0) ? 8'(forceM) : 8'($urandom);
    forceM = -1;
    {rdE, wrE, dW, sk} = 4'h0;
    r = m;
    fl = (flushN > 0);
    instrWord <= w;
    indexBase <= ix;
    regAddr <= ra;
    regWrData <= rd;
    regWrite <= (rk == 1);
    regRead <= (rk == 2);
    if (!w[8] && ext && f <= 8'h5f) a = ix + 14'(f);
    else if (!w[8]) a = (f < 8'h60) ? {6'h00, f} : {6'h3f, f};
    else a = {bank, f};
    #1;
    // Load the operand only after this edge's memory write has landed, or it would clobber it
    mem.poke(a, m);
    `CK(pc, pcE)
    `CK(qPhase, 2'h0)
    `CK(fetchFlush, ffE)
    // Bank and mode writes land at the decode edge, so the address above used the old ones
    if (rk == 1 && ra == 4'h0) ext = rd[0];
    if (rk == 1 && ra == 4'h4) bank = rd[5:0];
    if (rk == 1 && ra == 4'h8) wr = rd;
    ffE = 0;
    if (fl) begin
      if (firstFl && (w[15:12] == 4'hc || w[15:10] == 6'h3b)) flushN++;
      firstFl = 0;
      flushN--;
      pcE += 2;
    end else begin
      rdE = 1;
      pcE += 2;
      casez (w[15:9])
        7'b11010??: begin
          rdE = 0;
          pcE = pcE - 2 + {{9{w[10]}}, w[10:0], 1'b0};
          ffE = 1;
          flushN = 1;
        end
        7'b1000???: begin
          r = m | (8'h01 << w[11:9]);
          wrE = 1;
        end
        7'b000111?: begin
          r = ~m;
          nf = r[7];
          zf = (r == 8'h00);
          {dW, wrE} = {!w[9], w[9]};
        end
        7'b0110001: sk = (m == wr);
        7'b001011?: begin
          r = m - 8'h01;
          sk = (r == 8'h00);
          {dW, wrE} = {!w[9], w[9]};
        end
        7'b010011?: begin
          r = m - 8'h01;
          sk = (r != 8'h00);
          {dW, wrE} = {!w[9], w[9]};
        end
        default: rdE = 0;
      endcase
      if (sk) {ffE, firstFl, flushN} = {1'b1, 1'b1, 32'd1};
    end
    @(posedge ref_clk);
    regWrite <= 0;
    regRead <= 0;
    #1;
    `CK(regRdData, rk == 2 ? rd : 8'h00)
    `CK(memRead, rdE)
    if (rdE) `CK(memAddr, a)
    repeat (2) @(posedge ref_clk);
    #1;
    `CK(qPhase, 2'h3)
    `CK(memWrite, wrE)
    if (wrE) `CK(memWriteData, r)
    if (dW) wr = r;
    @(posedge ref_clk);
  endtask : slot

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    err_total++;
    close_out();
  end

  initial begin
    logic [15:0] w;
    logic [3:0] ra;
    int k, rk;
    void'($urandom(76893));
    repeat (3) @(posedge ref_clk);
    resetn <= 1;
    for (k = 0; k < 4; k++) slot(16'h0, 2, 4'(k * 4), 8'h00);
    for (k = 0; k < 3; k++) begin
      slot(16'h0, 1, 4'(k * 4), 8'hff);
      slot(16'h0, 2, 4'(k * 4), k == 0 ? 8'h01 : (k == 1 ? 8'h3f : 8'hff));
    end
    slot(16'h0, 1, 4'h2, 8'h5a);
    slot(16'h0, 2, 4'h2, 8'h00);
    // Extreme offsets, each followed by a word that must be dropped
    slot(16'hd400, 0, 4'h0, 8'h00);
    slot(16'h8e10, 2, 4'hc, {5'h0, 1'b1, nf, zf});
    slot(16'hd3ff, 0, 4'h0, 8'h00);
    slot(16'h8e10, 0, 4'h0, 8'h00);
    // Taken skips over a two-word instruction cost three cycles
    for (k = 0; k < 3; k++) begin
      forceM = (k == 2) ? int'(wr) : k + 1;
      slot(k == 0 ? 16'h2e05 : (k == 1 ? 16'h4e05 : 16'h6205), 0, 4'h0, 8'h00);
      slot(k == 1 ? 16'hec00 : 16'hc123, 2, 4'hc, {5'h0, 1'b1, nf, zf});
      slot(16'h8e10, 0, 4'h0, 8'h00);
    end
    for (k = 0; k < 90; k++) begin
      w = 16'($urandom);
      case (k % 7)
        0: w[15:11] = 5'h1a;
        1: w[15:12] = 4'h8;
        2: w[15:10] = 6'h07;
        3: w[15:9] = 7'h31;
        4: w[15:10] = 6'h0b;
        5: w[15:10] = 6'h13;
        default: ;
      endcase
      if (k % 4 == 0) forceM = int'(wr);
      if (k % 5 == 1) forceM = 1;
      rk = $urandom_range(0, 2);
      ra = (rk == 1) ? 4'($urandom_range(0, 2) * 4) : (k % 2 ? 4'hc : 4'h8);
      slot(w, rk, ra, rk == 1 ? 8'($urandom) : (ra == 4'hc ? {5'h0, flushN > 0, nf, zf} : wr));
    end
    close_out();
  end
endmodule : branch_bit_skip_instr_exec_test
